// [rtl/snap_pkg.sv]
package snap_pkg;
  // clock and refresh timing
  localparam int          CLK_PERIOD_NS   = 100;
  localparam int          TICK_MS         = 1;
  localparam int          TICK_CYC        = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int          INTERVAL_MIN_MS = 1000;
  localparam int          INTERVAL_MAX_MS = 65535;
  localparam logic [15:0] INTERVAL_RST    = 16'h03E8;

  // widths
  localparam int ADDR_W   = 32;
  localparam int ADDRESS_SPACE_IDENTIFIER_W   = 8;
  localparam int STAT_W   = 2;
  localparam int RATIO_W  = 16;
  localparam int PRIO_W   = 4;
  localparam int IB_CODE_W = 4;
  localparam int EB_CODE_W = 7;

  // internal bus state code bits
  localparam int IB_ACC = 3;
  localparam int IB_WR  = 2;
  // external bus state code bits
  localparam int EB_UNIT_HI = 6;
  localparam int EB_MODE    = 5;
  localparam int EB_DMA     = 4;
  localparam int EB_UNIT1   = 3;
  localparam int EB_UNIT0   = 2;
  localparam int EB_WR      = 1;
  localparam int EB_ACC     = 0;

  // apb register offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_IVAL   = 8'h08;
  localparam logic [7:0] OFS_STAT   = 8'h0C;
  localparam logic [7:0] OFS_IB     = 8'h10;
  localparam logic [7:0] OFS_IBADDR = 8'h14;
  localparam logic [7:0] OFS_EB     = 8'h18;
  localparam logic [7:0] OFS_EBADDR = 8'h1C;
  localparam logic [7:0] OFS_MISC   = 8'h20;
  localparam logic [7:0] OFS_RATIO  = 8'h24;

  // control register fields and reset value
  localparam int         CTRL_AUTO  = 0;
  localparam int         CTRL_BRK   = 1;
  localparam int         CTRL_MODE  = 2;
  localparam int         CTRL_LVL   = 4;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  typedef enum logic [2:0] {
    UNIT_8, UNIT_16, UNIT_32, UNIT_64, UNIT_32B
  } dma_unit_t;

  typedef enum logic [1:0] {
    IRQ_HOLD     = 2'b00,
    IRQ_NMI_ONLY = 2'b01,
    IRQ_ABOVE    = 2'b10
  } brk_irq_mode_t;

  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_CAP  = 2'b01,
    DEV_ANS  = 2'b11
  } dev_state_t;

  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_REQ  = 2'b01,
    HST_WAIT = 2'b11
  } hst_state_t;
endpackage : snap_pkg

// [rtl/snap_if.sv]
interface snap_if;
  logic                            req;
  logic                            ack;
  logic                            brk;
  logic [1:0]                      irq_mode;
  logic [snap_pkg::PRIO_W-1:0]     irq_level;
  logic                            valid;
  logic                            sleep;
  logic [snap_pkg::IB_CODE_W-1:0]  ib_code;
  logic [snap_pkg::ADDR_W-1:0]     ib_addr;
  logic [snap_pkg::EB_CODE_W-1:0]  eb_code;
  logic [snap_pkg::ADDR_W-1:0]     eb_addr;
  logic                            at_bit;
  logic [snap_pkg::ADDRESS_SPACE_IDENTIFIER_W-1:0]     address_space_identifier;
  logic [snap_pkg::STAT_W-1:0]     status_pins;
  logic [snap_pkg::RATIO_W-1:0]    clk_ratio;

  modport dev (input req, brk, irq_mode, irq_level,
               output ack, valid, sleep, ib_code, ib_addr, eb_code,
               eb_addr, at_bit, address_space_identifier, status_pins, clk_ratio);
  modport host (output req, brk, irq_mode, irq_level,
                input ack, valid, sleep, ib_code, ib_addr, eb_code,
                eb_addr, at_bit, address_space_identifier, status_pins, clk_ratio);
endinterface : snap_if

// [rtl/snap_code_enc.sv]
module snap_code_enc (
  input  wire logic                           ls_valid_i,
  input  wire logic                           ls_write_i,
  input  wire logic [1:0]                     ls_size_i,
  input  wire logic                           ext_valid_i,
  input  wire logic                           ext_write_i,
  input  wire logic                           ext_dma_i,
  input  wire logic                           ext_steal_i,
  input  wire snap_pkg::dma_unit_t            ext_unit_i,
  output logic [snap_pkg::IB_CODE_W-1:0]      ib_code_o,
  output logic [snap_pkg::EB_CODE_W-1:0]      eb_code_o
);
  always_comb begin
    ib_code_o = '0;
    ib_code_o[snap_pkg::IB_ACC] = ls_valid_i;
    if (ls_valid_i) begin
      ib_code_o[snap_pkg::IB_WR] = ls_write_i;
      ib_code_o[1:0]             = ls_size_i;
    end
  end

  always_comb begin
    eb_code_o = '0;
    eb_code_o[snap_pkg::EB_ACC] = ext_valid_i;
    if (ext_valid_i) begin
      eb_code_o[snap_pkg::EB_WR]  = ext_write_i;
      eb_code_o[snap_pkg::EB_DMA] = ext_dma_i;
      // unit reflects the on-chip access size, cpu accesses too
      unique case (ext_unit_i)
        snap_pkg::UNIT_8:   eb_code_o[3:2] = 2'h1;
        snap_pkg::UNIT_16:  eb_code_o[3:2] = 2'h2;
        snap_pkg::UNIT_32:  eb_code_o[3:2] = 2'h3;
        snap_pkg::UNIT_64:  eb_code_o[3:2] = 2'h0;
        snap_pkg::UNIT_32B: eb_code_o[3:2] = 2'h0;
        default:            eb_code_o[3:2] = 2'h0;
      endcase
      if (ext_dma_i) begin
        // mode and unit bit 6 mean nothing for a cpu access
        eb_code_o[snap_pkg::EB_MODE]    = ext_steal_i;
        eb_code_o[snap_pkg::EB_UNIT_HI] =
          (ext_unit_i == snap_pkg::UNIT_32B);
      end
    end
  end
endmodule : snap_code_enc

// [rtl/snap_monitor.sv]
// How it works
// - internal code bit 3 flags load/store access
// - bit 3 low: other internal fields invalid
// - internal code bit 2: read 0, write 1
// - internal bits 1:0 give access width
// - external bit 5: burst 0, cycle steal 1
// - external bit 4: CPU 0, DMA 1
// - bits 6,3,2 give DMA transfer unit
// - external bit 1: read 0, write 1
// - external bit 0 flags access, else invalid
// - CPU access: bits 5 and 6 invalid
// - capture internal bus address
// - capture external bus address
// - capture translation enable and space id
// - capture status pin levels
// - samples valid only while program runs
// - sleep: only status pins and ratio
// - host refresh interval 1000 to 65535 ms
// - hold interrupts arriving during break
// - break servicing: NMI only or above level
//
// Local design decisions: the APB slave port and the register addresses.
module snap_monitor (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_b_i,
  snap_if.dev                                lnk,
  input  wire logic                          cpu_reset_i,
  input  wire logic                          cpu_sleep_i,
  input  wire logic                          ls_valid_i,
  input  wire logic                          ls_write_i,
  input  wire logic [1:0]                    ls_size_i,
  input  wire logic [snap_pkg::ADDR_W-1:0]   ls_addr_i,
  input  wire logic                          ext_valid_i,
  input  wire logic                          ext_write_i,
  input  wire logic                          ext_dma_i,
  input  wire logic                          ext_steal_i,
  input  wire snap_pkg::dma_unit_t           ext_unit_i,
  input  wire logic [snap_pkg::ADDR_W-1:0]   ext_addr_i,
  input  wire logic                          mmu_at_i,
  input  wire logic [snap_pkg::ADDRESS_SPACE_IDENTIFIER_W-1:0]   address_space_identifier_i,
  input  wire logic [snap_pkg::STAT_W-1:0]   status_pins_i,
  input  wire logic [snap_pkg::RATIO_W-1:0]  clk_ratio_i,
  input  wire logic                          int_irq_i,
  input  wire logic                          ext_irq_i,
  input  wire logic                          nmi_i,
  input  wire logic [snap_pkg::PRIO_W-1:0]   irq_prio_i,
  output logic                               irq_take_o,
  output logic                               irq_take_nmi_o,
  output logic [snap_pkg::PRIO_W-1:0]        irq_take_prio_o,
  output logic                               irq_pending_o
);
  snap_pkg::dev_state_t                  state_r;
  snap_pkg::dev_state_t                  state_nxt;
  logic [snap_pkg::IB_CODE_W-1:0]        ib_code;
  logic [snap_pkg::EB_CODE_W-1:0]        eb_code;
  logic                                  ext_irq_prev_r;
  logic                                  irq_evt;
  logic                                  evt_ok;
  logic                                  pend_ok;
  logic                                  pend_r;
  logic                                  pend_nmi_r;
  logic [snap_pkg::PRIO_W-1:0]           pend_prio_r;
  logic                                  ack_r;
  logic                                  capture;

  // is an interrupt of this kind let through during a break
  function automatic logic brk_allows(
    input logic                        mode_ok_nmi,
    input logic [1:0]                  mode,
    input logic [snap_pkg::PRIO_W-1:0] prio,
    input logic [snap_pkg::PRIO_W-1:0] level
  );
    logic ok;
    ok = 1'b0;
    if (mode == snap_pkg::IRQ_NMI_ONLY) begin
      ok = mode_ok_nmi;
    end else if (mode == snap_pkg::IRQ_ABOVE) begin
      ok = mode_ok_nmi || (prio > level);
    end
    return ok;
  endfunction : brk_allows

  snap_code_enc u_enc (
    .ls_valid_i  (ls_valid_i),
    .ls_write_i  (ls_write_i),
    .ls_size_i   (ls_size_i),
    .ext_valid_i (ext_valid_i),
    .ext_write_i (ext_write_i),
    .ext_dma_i   (ext_dma_i),
    .ext_steal_i (ext_steal_i),
    .ext_unit_i  (ext_unit_i),
    .ib_code_o   (ib_code),
    .eb_code_o   (eb_code)
  );

  // request handshake: idle, capture, answer
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      snap_pkg::DEV_IDLE: if (lnk.req) state_nxt = snap_pkg::DEV_CAP;
      snap_pkg::DEV_CAP:  state_nxt = snap_pkg::DEV_ANS;
      snap_pkg::DEV_ANS:  if (!lnk.req) state_nxt = snap_pkg::DEV_IDLE;
      default:            state_nxt = snap_pkg::DEV_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= snap_pkg::DEV_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign capture = (state_r == snap_pkg::DEV_CAP);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= capture;
    end
  end
  assign lnk.ack = ack_r;

  // one snapshot register bank, loaded in a single edge
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.valid       <= 1'b0;
      lnk.sleep       <= 1'b0;
      lnk.ib_code     <= '0;
      lnk.ib_addr     <= '0;
      lnk.eb_code     <= '0;
      lnk.eb_addr     <= '0;
      lnk.at_bit      <= 1'b0;
      lnk.address_space_identifier        <= '0;
      lnk.status_pins <= '0;
      lnk.clk_ratio   <= '0;
    end else if (capture) begin
      lnk.valid       <= !lnk.brk && !cpu_reset_i;
      lnk.sleep       <= cpu_sleep_i;
      lnk.status_pins <= status_pins_i;
      lnk.clk_ratio   <= clk_ratio_i;
      if (cpu_sleep_i) begin
        // asleep: everything but pins, ratio, valid and the sleep flag reads zero
        lnk.ib_code <= '0;
        lnk.ib_addr <= '0;
        lnk.eb_code <= '0;
        lnk.eb_addr <= '0;
        lnk.at_bit  <= 1'b0;
        lnk.address_space_identifier    <= '0;
      end else begin
        lnk.ib_code <= ib_code;
        lnk.ib_addr <= ls_valid_i ? ls_addr_i : '0;
        lnk.eb_code <= eb_code;
        lnk.eb_addr <= ext_valid_i ? ext_addr_i : '0;
        lnk.at_bit  <= mmu_at_i;
        lnk.address_space_identifier    <= address_space_identifier_i;
      end
    end
  end

  // interrupt holding during a break
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext_irq_prev_r <= 1'b0;
    end else begin
      ext_irq_prev_r <= ext_irq_i;
    end
  end

  assign irq_evt = int_irq_i || nmi_i || (ext_irq_i && !ext_irq_prev_r);
  assign evt_ok  = !lnk.brk ||
                   brk_allows(nmi_i, lnk.irq_mode, irq_prio_i,
                              lnk.irq_level);
  assign pend_ok = !lnk.brk ||
                   brk_allows(pend_nmi_r, lnk.irq_mode, pend_prio_r,
                              lnk.irq_level);

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_r      <= 1'b0;
      pend_nmi_r  <= 1'b0;
      pend_prio_r <= '0;
    end else if (irq_evt && (!evt_ok || (pend_r && pend_ok))) begin
      // new event kept even while the old one is released
      pend_r      <= 1'b1;
      pend_nmi_r  <= (pend_r && !pend_ok && pend_nmi_r) || nmi_i;
      pend_prio_r <= (pend_r && !pend_ok && pend_prio_r > irq_prio_i) ?
                     pend_prio_r : irq_prio_i;
    end else if (pend_r && pend_ok) begin
      pend_r      <= 1'b0;
      pend_nmi_r  <= 1'b0;
      pend_prio_r <= '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_take_o      <= 1'b0;
      irq_take_nmi_o  <= 1'b0;
      irq_take_prio_o <= '0;
    end else if (pend_r && pend_ok) begin
      irq_take_o      <= 1'b1;
      irq_take_nmi_o  <= pend_nmi_r;
      irq_take_prio_o <= pend_prio_r;
    end else if (irq_evt && evt_ok) begin
      irq_take_o      <= 1'b1;
      irq_take_nmi_o  <= nmi_i;
      irq_take_prio_o <= irq_prio_i;
    end else begin
      irq_take_o      <= 1'b0;
      irq_take_nmi_o  <= 1'b0;
      irq_take_prio_o <= '0;
    end
  end

  assign irq_pending_o = pend_r;
endmodule : snap_monitor

// [rtl/snap_host.sv]
module snap_host #(
  parameter int TICK_CYC = snap_pkg::TICK_CYC
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  snap_if.host             lnk,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o
);
  snap_pkg::hst_state_t state_r;
  logic [7:0]           ctrl_r;
  logic [15:0]          ival_r;
  logic [15:0]          ms_cnt_r;
  logic [31:0]          tick_cnt_r;
  logic                 tick;
  logic                 cmd_r;
  logic                 due;
  logic                 done_r;
  logic                 mapped;
  logic                 wr;
  logic                 setup;
  logic [3:0]           ib_r;
  logic [31:0]          ibaddr_r;
  logic [6:0]           eb_r;
  logic [31:0]          ebaddr_r;
  logic [31:0]          misc_r;
  logic [15:0]          ratio_r;
  logic [15:0]          ival_in;

  assign setup = psel_i && !penable_i;
  assign wr    = psel_i && penable_i && pwrite_i && !pslverr_o;
  assign pready_o = 1'b1;
  always_comb begin
    unique case (paddr_i)
      snap_pkg::OFS_CTRL, snap_pkg::OFS_CMD, snap_pkg::OFS_IVAL,
      snap_pkg::OFS_STAT, snap_pkg::OFS_IB, snap_pkg::OFS_IBADDR,
      snap_pkg::OFS_EB, snap_pkg::OFS_EBADDR, snap_pkg::OFS_MISC,
      snap_pkg::OFS_RATIO: mapped = 1'b1;
      default:             mapped = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i && penable_i && !mapped;

  // interval raised to the 1000 ms minimum, data bits above 15 dropped
  assign ival_in = (pwdata_i[15:0] < 16'(snap_pkg::INTERVAL_MIN_MS)) ?
                   16'(snap_pkg::INTERVAL_MIN_MS) : pwdata_i[15:0];

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r <= snap_pkg::CTRL_RST;
      ival_r <= snap_pkg::INTERVAL_RST;
    end else if (wr && paddr_i == snap_pkg::OFS_CTRL) begin
      ctrl_r <= pwdata_i[7:0];
    end else if (wr && paddr_i == snap_pkg::OFS_IVAL) begin
      ival_r <= ival_in;
    end
  end

  assign lnk.brk       = ctrl_r[snap_pkg::CTRL_BRK];
  assign lnk.irq_mode  = ctrl_r[snap_pkg::CTRL_MODE +: 2];
  assign lnk.irq_level = ctrl_r[snap_pkg::CTRL_LVL +: 4];

  // millisecond tick and refresh interval
  assign tick = (tick_cnt_r == 32'(TICK_CYC - 1));
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= '0;
    end else if (!ctrl_r[snap_pkg::CTRL_AUTO] || due) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= ms_cnt_r + 16'h0001;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign due = ctrl_r[snap_pkg::CTRL_AUTO] && tick &&
               (ms_cnt_r == ival_r - 16'h0001);

  // command latch: set wins over the clear on request issue
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_r <= 1'b0;
    end else if (due ||
                 (wr && paddr_i == snap_pkg::OFS_CMD && pwdata_i[0])) begin
      cmd_r <= 1'b1;
    end else if (state_r == snap_pkg::HST_IDLE) begin
      cmd_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= snap_pkg::HST_IDLE;
    end else begin
      unique case (state_r)
        snap_pkg::HST_IDLE: if (cmd_r) state_r <= snap_pkg::HST_REQ;
        snap_pkg::HST_REQ:  if (lnk.ack) state_r <= snap_pkg::HST_WAIT;
        snap_pkg::HST_WAIT: state_r <= snap_pkg::HST_IDLE;
        default:            state_r <= snap_pkg::HST_IDLE;
      endcase
    end
  end
  assign lnk.req = (state_r == snap_pkg::HST_REQ);

  // stored sample, invalid fields forced to zero
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ib_r     <= '0;
      ibaddr_r <= '0;
      eb_r     <= '0;
      ebaddr_r <= '0;
      misc_r   <= '0;
      ratio_r  <= '0;
      done_r   <= 1'b0;
    end else if (lnk.req && lnk.ack) begin
      done_r   <= 1'b1;
      ratio_r  <= lnk.clk_ratio;
      ib_r     <= lnk.ib_code[snap_pkg::IB_ACC] ? lnk.ib_code : '0;
      ibaddr_r <= lnk.ib_code[snap_pkg::IB_ACC] ? lnk.ib_addr : '0;
      ebaddr_r <= lnk.eb_code[snap_pkg::EB_ACC] ? lnk.eb_addr : '0;
      if (!lnk.eb_code[snap_pkg::EB_ACC]) begin
        eb_r <= '0;
      end else if (!lnk.eb_code[snap_pkg::EB_DMA]) begin
        eb_r <= lnk.eb_code & 7'h1F;
      end else begin
        eb_r <= lnk.eb_code;
      end
      misc_r   <= {20'h0_0000, lnk.valid, lnk.status_pins, lnk.address_space_identifier,
                   lnk.at_bit};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_o <= '0;
    end else if (setup && !pwrite_i) begin
      unique case (paddr_i)
        snap_pkg::OFS_CTRL:   prdata_o <= {24'h00_0000, ctrl_r};
        snap_pkg::OFS_IVAL:   prdata_o <= {16'h0000, ival_r};
        snap_pkg::OFS_STAT:   prdata_o <= {30'h0, done_r,
                                           state_r != snap_pkg::HST_IDLE};
        snap_pkg::OFS_IB:     prdata_o <= {28'h000_0000, ib_r};
        snap_pkg::OFS_IBADDR: prdata_o <= ibaddr_r;
        snap_pkg::OFS_EB:     prdata_o <= {25'h000_0000, eb_r};
        snap_pkg::OFS_EBADDR: prdata_o <= ebaddr_r;
        snap_pkg::OFS_MISC:   prdata_o <= misc_r;
        snap_pkg::OFS_RATIO:  prdata_o <= {16'h0000, ratio_r};
        default:              prdata_o <= '0;
      endcase
    end
  end
endmodule : snap_host

// [tb/snap_checker.sv]
module snap_checker (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        req,
  input wire logic        ack,
  input wire logic        brk,
  input wire logic        valid,
  input wire logic        sleep,
  input wire logic [3:0]  ib_code,
  input wire logic [31:0] ib_addr,
  input wire logic [6:0]  eb_code,
  input wire logic [31:0] eb_addr,
  input wire logic        at_bit,
  input wire logic [7:0]  address_space_identifier,
  input wire logic [1:0]  status_pins,
  input wire logic [15:0] clk_ratio
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_ib_invalid: assert property (
    !ib_code[3] |-> ib_code == 4'h0 && ib_addr == 32'h0)
    else $error("internal fields set without access");
  a_eb_invalid: assert property (
    !eb_code[0] |-> eb_code == 7'h00 && eb_addr == 32'h0)
    else $error("external fields set without access");
  a_cpu_mode_clear: assert property (
    eb_code[0] && !eb_code[4] |-> eb_code[6:5] == 2'h0)
    else $error("cpu access shows dma mode bits");
  a_sleep_only_pins: assert property (
    sleep |-> {ib_code, eb_code, ib_addr, eb_addr, at_bit, address_space_identifier} == 0)
    else $error("sleep sample carries bus fields");
  a_brk_no_valid: assert property (
    ack && $past(brk) && $past(brk, 2) && $past(brk, 3) |-> !valid)
    else $error("sample marked valid during break");
  a_ack_one_cycle: assert property (
    ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_after_req: assert property (
    $rose(ack) |-> $past(req) && $past(req, 2))
    else $error("ack without request");
  a_ack_in_time: assert property (
    $rose(req) |-> ##2 ack)
    else $error("ack late");
  a_req_drop: assert property (
    ack |=> !req)
    else $error("request held after ack");
  a_sample_stable: assert property (
    !ack |-> $stable({ib_code, ib_addr, eb_code, eb_addr, at_bit, address_space_identifier,
                      status_pins, clk_ratio, valid, sleep}))
    else $error("sample field changed outside capture");
endmodule : snap_checker

// [tb/tb_cpu_status_snapshot_monitor.sv]
module tb_cpu_status_snapshot_monitor;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ones = 32'hFFFF_FFFF;
  logic                clk = 1'h0;
  logic                rst_b = 1'h0;
  logic                ps = 1'h0, pe = 1'h0, pw = 1'h0;
  logic [7:0]          pa = 8'h00;
  logic [31:0]         pd = 32'h0, prd;
  logic                rdy, err, tk, tkn, pend, bk;
  logic [3:0]          tkp, pr = 4'h0;
  logic                cres = 1'h0, slp = 1'h0, lv = 1'h0, lw = 1'h0;
  logic                ev = 1'h0, ew = 1'h0, ed = 1'h0, es = 1'h0;
  logic                at = 1'h0, ii = 1'h0, xi = 1'h0, nmi = 1'h0;
  logic [1:0]          lsz = 2'h0, pins = 2'h0;
  logic [31:0]         la = 32'h0, ea = 32'h0;
  logic [7:0]          address_space_identifier = 8'h00;
  logic [15:0]         rat = 16'h0000;
  snap_pkg::dma_unit_t eu = snap_pkg::UNIT_8;
  logic [32:0]         eq[$], mq[$];
  logic [4:0]          iq[$], e;
  logic [31:0]         iv[3] = '{32'h0000_01F4, 32'h0000_07D0, 32'h0000_FFFF};
  int                  fails = 0, n_tests = 0;

  snap_if lnk();
  always #50 clk = ~clk;

  snap_monitor i_snap_monitor (
    .ref_clk_i(clk), .rst_b_i(rst_b), .lnk(lnk), .cpu_reset_i(cres),
    .cpu_sleep_i(slp), .ls_valid_i(lv), .ls_write_i(lw), .ls_size_i(lsz),
    .ls_addr_i(la), .ext_valid_i(ev), .ext_write_i(ew), .ext_dma_i(ed),
    .ext_steal_i(es), .ext_unit_i(eu), .ext_addr_i(ea), .mmu_at_i(at),
    .address_space_identifier_i(address_space_identifier), .status_pins_i(pins), .clk_ratio_i(rat),
    .int_irq_i(ii), .ext_irq_i(xi), .nmi_i(nmi), .irq_prio_i(pr),
    .irq_take_o(tk), .irq_take_nmi_o(tkn), .irq_take_prio_o(tkp),
    .irq_pending_o(pend));
  snap_host #(.TICK_CYC(4)) i_snap_host (
    .ref_clk_i(clk), .rst_b_i(rst_b), .lnk(lnk), .psel_i(ps),
    .penable_i(pe), .pwrite_i(pw), .paddr_i(pa), .pwdata_i(pd),
    .prdata_o(prd), .pready_o(rdy), .pslverr_o(err));
  snap_checker i_snap_checker (
    .ref_clk_i(clk), .rst_b_i(rst_b), .req(lnk.req), .ack(lnk.ack),
    .brk(lnk.brk), .valid(lnk.valid), .sleep(lnk.sleep),
    .ib_code(lnk.ib_code), .ib_addr(lnk.ib_addr), .eb_code(lnk.eb_code),
    .eb_addr(lnk.eb_addr), .at_bit(lnk.at_bit), .address_space_identifier(lnk.address_space_identifier),
    .status_pins(lnk.status_pins), .clk_ratio(lnk.clk_ratio));

  task test_done;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  task cmp(input logic [32:0] g, x, m);
    n_tests++;
    if ((g & m) !== (x & m)) begin
      fails++;
      $display("unexpected at %0t got %h exp %h", $time, g, x);
    end
  endtask : cmp

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    ps <= 1'h1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge clk);
    pe <= 1'h1;
    do @(posedge clk); while (rdy !== 1'h1);
    ps <= 1'h0;
    pe <= 1'h0;
    @(posedge clk);
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] x, m, input logic er);
    eq.push_back({er, x});
    mq.push_back({1'h1, m});
    apb(1'h0, a, 32'h0);
  endtask : rd

  task ctrl(input logic b, input logic [1:0] m, input logic [3:0] l);
    bk = b;
    apb(1'h1, snap_pkg::OFS_CTRL, {24'h0, l, m, b, 1'h0});
    repeat (2) @(posedge clk);
  endtask : ctrl

  function automatic logic [2:0] unit(snap_pkg::dma_unit_t x);
    case (x)
      snap_pkg::UNIT_8:   return 3'h1;
      snap_pkg::UNIT_16:  return 3'h2;
      snap_pkg::UNIT_32:  return 3'h3;
      snap_pkg::UNIT_32B: return 3'h4;
      default:            return 3'h0;
    endcase
  endfunction : unit

  task rnd(input int k);
    {lv, lw, lsz, ev, ew, ed, es, at, pins} <= 11'($urandom);
    la <= $urandom;
    ea <= $urandom;
    address_space_identifier <= 8'($urandom);
    rat <= 16'($urandom);
    eu <= snap_pkg::dma_unit_t'(k % 5);
    @(posedge clk);
  endtask : rnd

  task samp;
    logic [2:0] u;
    logic [3:0] ic;
    logic [6:0] ec, em;
    apb(1'h1, snap_pkg::OFS_CMD, 32'h0000_0001);
    for (int i = 0; i < 20 && lnk.ack !== 1'h1; i++) @(posedge clk);
    cmp(33'(lnk.ack), 33'h1, 33'h1);
    repeat (2) @(posedge clk);
    u = unit(eu);
    ic = (lv && !slp) ? {1'h1, lw, lsz} : 4'h0;
    ec = (ev && !slp) ? {u[2], es, ed, u[1:0], ew, 1'h1} : 7'h00;
    em = !ec[0] ? 7'h7F : !ed ? 7'h1F : (u[1:0] != 2'h0) ? 7'h3F : 7'h7F;
    if (bk || cres) begin
      rd(snap_pkg::OFS_MISC, 32'h0, 32'h0000_0800, 1'h0);
    end else begin
      rd(snap_pkg::OFS_IB, {28'h0, ic}, ones, 1'h0);
      rd(snap_pkg::OFS_IBADDR, ic[3] ? la : 32'h0, ones, 1'h0);
      rd(snap_pkg::OFS_EB, {25'h0, ec}, {25'h0, em}, 1'h0);
      rd(snap_pkg::OFS_EBADDR, ec[0] ? ea : 32'h0, ones, 1'h0);
      rd(snap_pkg::OFS_MISC, {20'h0, 1'h1, pins, slp ? 8'h00 : address_space_identifier,
         at && !slp}, slp ? 32'hFFFF_F7FF : ones, 1'h0);
      rd(snap_pkg::OFS_RATIO, {16'h0, rat}, ones, 1'h0);
      rd(snap_pkg::OFS_STAT, 32'h0000_0002, 32'h0000_0002, 1'h0);
    end
  endtask : samp

  task ev_irq(input logic [1:0] k, input logic [3:0] p);
    pr <= p;
    ii <= (k == 2'h0);
    xi <= (k == 2'h1);
    nmi <= (k == 2'h2);
    @(posedge clk);
    ii <= 1'h0;
    xi <= 1'h0;
    nmi <= 1'h0;
    repeat (3) @(posedge clk);
  endtask : ev_irq

  // results come back in order: apb reads and interrupt deliveries
  always @(posedge clk) begin
    if (ps && pe && rdy === 1'h1 && !pw) begin
      cmp({err, prd}, eq.pop_front(), mq.pop_front());
    end
    if (tk === 1'h1) begin
      e = iq.pop_front();
      cmp(33'({tkn, tkp}), 33'(e), e[4] ? 33'h10 : 33'h1F);
    end
  end

  initial begin
    #3_000_000;
    fails++;
    test_done();
  end

  initial begin
    bk = 1'h0;
    void'($urandom(52));
    repeat (8) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    rd(snap_pkg::OFS_CTRL, {24'h0, snap_pkg::CTRL_RST}, ones, 1'h0);
    rd(snap_pkg::OFS_IVAL, {16'h0, snap_pkg::INTERVAL_RST}, ones, 1'h0);
    rd(8'h30, 32'h0, ones, 1'h1);
    rd(snap_pkg::OFS_CMD, 32'h0, ones, 1'h0);
    for (int i = 0; i < 3; i++) begin
      apb(1'h1, snap_pkg::OFS_IVAL, iv[i]);
      rd(snap_pkg::OFS_IVAL, iv[i] < 32'h0000_03E8 ? 32'h0000_03E8 : iv[i],
         ones, 1'h0);
    end
    for (int k = 0; k < 15; k++) begin
      rnd(k);
      samp();
    end
    slp <= 1'h1;
    rnd(1);
    samp();
    slp <= 1'h0;
    cres <= 1'h1;
    rnd(2);
    samp();
    cres <= 1'h0;
    ctrl(1'h1, 2'h0, 4'h0);
    rnd(3);
    samp();
    ctrl(1'h0, 2'h0, 4'h0);
    iq.push_back(5'h03);
    ev_irq(2'h0, 4'h3);
    iq.push_back(5'h06);
    ev_irq(2'h1, 4'h6);
    // per mode: one event let through (NMI-only and above-level modes), then one held until release
    for (int m = 0; m < 3; m++) begin
      ctrl(1'h1, 2'(m), 4'h7);
      if (m != 0) begin
        iq.push_back({m == 1, 4'h8});
        ev_irq(m == 1 ? 2'h2 : 2'h0, 4'h8);
      end
      ev_irq(m == 0 ? 2'h1 : 2'h0, 4'h7);
      cmp(33'(pend), 33'h1, 33'h1);
      iq.push_back(5'h07);
      ctrl(1'h0, 2'h0, 4'h0);
      cmp(33'(pend), 33'h0, 33'h1);
    end
    // sleep sample clears the code, then only the timer may refresh it
    slp <= 1'h1;
    rnd(4);
    samp();
    slp <= 1'h0;
    lv <= 1'h1;
    apb(1'h1, snap_pkg::OFS_IVAL, 32'h0);
    apb(1'h1, snap_pkg::OFS_CTRL, 32'h0000_0001);
    repeat (3980) @(posedge clk);
    rd(snap_pkg::OFS_IB, 32'h0, 32'h0000_0008, 1'h0);
    repeat (30) @(posedge clk);
    rd(snap_pkg::OFS_IB, 32'h0000_0008, 32'h0000_0008, 1'h0);
    repeat (4) @(posedge clk);
    test_done();
  end
endmodule : tb_cpu_status_snapshot_monitor
